// file: logic/tsdc_pkg.sv
// Package: register map, field positions, reset values and carriers
package tsdc_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_STEP_CTRL = 8'h37;
  localparam logic [7:0] IDX_CEIL_1 = 8'h38;
  localparam logic [7:0] IDX_CEIL_2 = 8'h39;
  localparam logic [7:0] IDX_CEIL_3 = 8'h3a;
  // Registers of our own for the loose bits
  localparam logic [7:0] IDX_LOOP_CTRL = 8'h36;
  localparam logic [7:0] IDX_CONFIG = 8'h40;
  localparam logic [7:0] IDX_ALARM_CFG = 8'h7d;
  localparam logic [7:0] IDX_STATUS = 8'h80;
  // Field positions
  localparam int REMOTE_A_LSB = 0;
  localparam int LOCAL_LSB = 3;
  localparam int REMOTE_B_LSB = 6;
  localparam int REMOTE_B_MSB_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int CEIL_SEL_BIT = 3;
  // Reset values
  localparam logic [7:0] RST_STEP_CTRL = 8'h00;
  localparam logic [7:0] RST_CEIL = 8'hff;
  localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RST_ALARM_CFG = 8'h00;
  localparam logic [7:0] FULL_DUTY = 8'hff;
  // Decrease interval for code 000; each code step doubles it
  localparam int BASE_DEC_CYCLES = 8;
  localparam int CNT_W = 12;
  localparam int NUM_CH = 3;

  // Per-channel loop handshake carrier
  typedef struct packed {
    logic adj_dec;   // Step-down permitted level, high while count >= decrease wait
    logic adj_inc;   // Step-up permitted level, high while count >= increase wait
  } tsdc_adj_t;
endpackage : tsdc_pkg

// file: logic/tsdc_regs.sv
// Step-interval configuration and duty ceilings for a fan loop
// What this block does
// RQ1: Bits 2..0 of the step register set the first remote channel's step wait.
// RQ2: Bits 5..3 set the local channel's step wait.
// RQ3: Bits 7..6 give the low two bits of the second remote channel's code.
// RQ4: That combined code spaces the second remote channel's adjustments.
// RQ5: Decrease wait is 8 monitoring cycles for code 000, doubling up to 1024.
// RQ6: Increase wait is twice the decrease wait, 16 up to 2048 cycles.
// RQ7: The step register is all zeros after reset.
// RQ8: With the lock set, writes to the step register are ignored.
// RQ9: Three eight-bit duty ceilings sit at consecutive indexes from 0x38.
// RQ10: Each duty ceiling resets to 0xff, full duty.
// RQ11: With the lock set, writes to the duty ceilings are ignored.
// RQ12: On an alarm with ceiling select set, each fan goes to its ceiling.
// RQ13: On an alarm with ceiling select clear, each fan goes to full duty.
// RQ14: The second remote code's top bit is bit 0 of the loop control register.
// RQ15: The lock bit is set once and holds until the next reset.
// RQ16: Each channel counts its own interval, restarting after each change.
module tsdc_regs
  import tsdc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic clk_sys,                  // System clock, 50 MHz
  input wire logic resetn,                   // Synchronous reset, active low
  input wire logic wb_cyc_i,                 // Wishbone cycle
  input wire logic wb_stb_i,                 // Wishbone strobe
  input wire logic wb_we_i,                  // Wishbone write enable
  input wire logic [ADDR_W-1:0] wb_adr_i,    // Byte address
  input wire logic [31:0] wb_dat_i,          // Write data
  input wire logic [3:0] wb_sel_i,           // Byte selects
  output logic [31:0] wb_dat_o,              // Read data
  output logic wb_ack_o,                     // Acknowledge
  input wire logic mon_tick,                 // One monitoring cycle pulse
  input wire logic [2:0] step_done,          // Start temperature changed
  input wire logic thermal_alarm_pin,        // Overtemperature pin, async
  input wire logic [7:0] fan_drive_1_loop,   // Loop duty, fan 1
  input wire logic [7:0] fan_drive_2_loop,   // Loop duty, fan 2
  input wire logic [7:0] fan_drive_3_loop,   // Loop duty, fan 3
  output logic [2:0] dec_ok,                 // Decrease wait elapsed
  output logic [2:0] inc_ok,                 // Increase wait elapsed
  output logic [7:0] fan_drive_1,            // Duty to fan 1
  output logic [7:0] fan_drive_2,            // Duty to fan 2
  output logic [7:0] fan_drive_3,            // Duty to fan 3
  output logic locked                        // Lock state
);

  // Decrease wait in cycles for a 3-bit code
  function automatic logic [CNT_W-1:0] dec_cycles(input logic [2:0] code);
    dec_cycles = CNT_W'(BASE_DEC_CYCLES) << code; // RQ5
  endfunction : dec_cycles

  logic [7:0] step_ctrl_ff;
  logic [7:0] loop_ctrl_ff;
  logic [7:0] alarm_cfg_ff;
  logic [7:0] ceil_ff [NUM_CH];
  logic lock_ff;
  logic thermal_alarm_pin_s1_ff;
  logic thermal_alarm_pin_s2_ff;
  logic [2:0] code [NUM_CH];
  logic [CNT_W-1:0] cnt_ff [NUM_CH];
  tsdc_adj_t adj [NUM_CH];
  logic [7:0] loop_duty [NUM_CH];
  logic [7:0] nxt_drive [NUM_CH];
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic [31:0] nxt_dat;

  // All checks run on the system clock and rest during reset
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  assign idx = wb_adr_i[9:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Acknowledge one cycle after request, drop next cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= rd_en;
    end
  end

  // Acknowledge is a single-cycle pulse
  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

  // Lock bit, write-once until reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lock_ff <= 1'b0;
    end else if (wr_en && idx == IDX_CONFIG && wb_dat_i[LOCK_BIT]) begin
      lock_ff <= 1'b1; // RQ15
    end
  end

  // Lock only clears through reset
  a_lock_sticky: assert property ( // RQ15
    lock_ff |=> lock_ff)
    else $error("lock cleared without reset");

  // Step interval register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      step_ctrl_ff <= RST_STEP_CTRL; // RQ7
    end else if (wr_en && idx == IDX_STEP_CTRL && !lock_ff) begin // RQ8
      step_ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // Step register reset value, lock and write path
  a_step_reset_zero: assert property ( // RQ7
    $rose(resetn) |-> step_ctrl_ff == RST_STEP_CTRL)
    else $error("step register not zero after reset");
  a_step_lock_hold: assert property ( // RQ8
    lock_ff |=> $stable(step_ctrl_ff))
    else $error("step register changed while locked");
  a_step_write: assert property ( // RQ8
    wr_en && !lock_ff && idx == IDX_STEP_CTRL |=>
      step_ctrl_ff == $past(wb_dat_i[7:0]))
    else $error("step register write lost");

  // Loop control register holding the remote B code top bit
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      loop_ctrl_ff <= RST_LOOP_CTRL;
    end else if (wr_en && idx == IDX_LOOP_CTRL && !lock_ff) begin
      loop_ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // Loop control is frozen by the lock as well
  a_loop_lock_hold: assert property ( // RQ15
    lock_ff |=> $stable(loop_ctrl_ff))
    else $error("loop control changed while locked");

  // Alarm configuration, ceiling select bit
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alarm_cfg_ff <= RST_ALARM_CFG;
    end else if (wr_en && idx == IDX_ALARM_CFG) begin
      alarm_cfg_ff <= wb_dat_i[7:0];
    end
  end

  // Duty ceilings at consecutive indexes
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!resetn) begin
        ceil_ff[i] <= RST_CEIL; // RQ10
      end else if (wr_en && !lock_ff &&
                   idx == IDX_CEIL_1 + 8'(i)) begin // RQ9 RQ11
        ceil_ff[i] <= wb_dat_i[7:0];
      end
    end
  end

  // Ceilings: reset value, lock and write path
  a_ceil_lock_hold: assert property ( // RQ11
    lock_ff |=> $stable(ceil_ff[0]) && $stable(ceil_ff[1])
      && $stable(ceil_ff[2]))
    else $error("ceiling changed while locked");
  a_ceil_write: assert property ( // RQ9
    wr_en && !lock_ff && idx == IDX_CEIL_2 |=>
      ceil_ff[1] == $past(wb_dat_i[7:0]))
    else $error("ceiling 2 write lost");
  a_ceil_reset: assert property ( // RQ10
    $rose(resetn) |-> ceil_ff[0] == RST_CEIL && ceil_ff[1] == RST_CEIL
      && ceil_ff[2] == RST_CEIL)
    else $error("ceiling reset value wrong");

  // Read mux; unmapped indexes read zero
  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (idx)
      IDX_STEP_CTRL: nxt_dat[7:0] = step_ctrl_ff;
      IDX_LOOP_CTRL: nxt_dat[7:0] = loop_ctrl_ff;
      IDX_ALARM_CFG: nxt_dat[7:0] = alarm_cfg_ff;
      IDX_CEIL_1: nxt_dat[7:0] = ceil_ff[0];
      IDX_CEIL_2: nxt_dat[7:0] = ceil_ff[1];
      IDX_CEIL_3: nxt_dat[7:0] = ceil_ff[2];
      IDX_CONFIG: nxt_dat[LOCK_BIT] = lock_ff;
      IDX_STATUS: nxt_dat[7:0] = {5'h00, thermal_alarm_pin_s2_ff, dec_ok[0], lock_ff};
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= nxt_dat;
    end
  end

  // Only byte lane 0 ever carries read data
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper lanes not zero");

  // Per-channel codes
  assign code[0] = step_ctrl_ff[REMOTE_A_LSB +: 3]; // RQ1
  assign code[1] = step_ctrl_ff[LOCAL_LSB +: 3]; // RQ2
  assign code[2] = {loop_ctrl_ff[REMOTE_B_MSB_BIT],
                    step_ctrl_ff[REMOTE_B_LSB +: 2]}; // RQ3 RQ14 RQ4

  // Interval counters, one per channel
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!resetn || step_done[i]) begin
        cnt_ff[i] <= '0; // RQ16
      end else if (mon_tick && cnt_ff[i] != {CNT_W{1'b1}}) begin
        cnt_ff[i] <= cnt_ff[i] + 1'b1;
      end
    end
  end

  // A start temperature change restarts the count
  a_restart_count: assert property ( // RQ16
    step_done[2] |=> cnt_ff[2] == '0 ##1 !inc_ok[2])
    else $error("count not restarted");

  // Wait comparisons use the current code at every count
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      adj[i].adj_dec = cnt_ff[i] >= dec_cycles(code[i]); // RQ5
      adj[i].adj_inc = cnt_ff[i] >= (dec_cycles(code[i]) << 1); // RQ6
    end
  end

  // Registered permission flags
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!resetn) begin
        dec_ok[i] <= 1'b0;
        inc_ok[i] <= 1'b0;
      end else begin
        dec_ok[i] <= adj[i].adj_dec && !step_done[i];
        inc_ok[i] <= adj[i].adj_inc && !step_done[i];
      end
    end
  end

  // Waits against values worked out from the fields themselves
  a_dec_code0: assert property ( // RQ1 RQ5
    code[0] == 3'h0 && cnt_ff[0] == 12'h007 && !step_done[0]
      |=> !dec_ok[0])
    else $error("remote a released early");
  a_inc_double: assert property ( // RQ2 RQ6
    cnt_ff[1] == CNT_W'(2 * BASE_DEC_CYCLES) << code[1] && !step_done[1]
      |=> inc_ok[1])
    else $error("local increase wait wrong");
  a_remote_b_msb: assert property ( // RQ3 RQ4 RQ14
    !step_done[2] && cnt_ff[2] + 1'b1 == CNT_W'(BASE_DEC_CYCLES) <<
      {loop_ctrl_ff[REMOTE_B_MSB_BIT], step_ctrl_ff[REMOTE_B_LSB +: 2]}
      |=> !dec_ok[2])
    else $error("remote b wait does not follow its code fields");

  // Alarm pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      thermal_alarm_pin_s1_ff <= 1'b0;
      thermal_alarm_pin_s2_ff <= 1'b0;
    end else begin
      thermal_alarm_pin_s1_ff <= thermal_alarm_pin;
      thermal_alarm_pin_s2_ff <= thermal_alarm_pin_s1_ff;
    end
  end

  assign loop_duty[0] = fan_drive_1_loop;
  assign loop_duty[1] = fan_drive_2_loop;
  assign loop_duty[2] = fan_drive_3_loop;

  // Alarm override of fan duty
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!thermal_alarm_pin_s2_ff) begin
        nxt_drive[i] = loop_duty[i];
      end else if (alarm_cfg_ff[CEIL_SEL_BIT]) begin
        nxt_drive[i] = ceil_ff[i]; // RQ12
      end else begin
        nxt_drive[i] = FULL_DUTY; // RQ13
      end
    end
  end

  // Registered fan outputs and lock flag
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fan_drive_1 <= 8'h00;
      fan_drive_2 <= 8'h00;
      fan_drive_3 <= 8'h00;
      locked <= 1'b0;
    end else begin
      fan_drive_1 <= nxt_drive[0];
      fan_drive_2 <= nxt_drive[1];
      fan_drive_3 <= nxt_drive[2];
      locked <= lock_ff;
    end
  end

  // Fans follow the loop without alarm, and the override with it
  sequence s_alarm_ceil;
    thermal_alarm_pin_s2_ff && alarm_cfg_ff[CEIL_SEL_BIT];
  endsequence
  sequence s_alarm_full;
    thermal_alarm_pin_s2_ff && !alarm_cfg_ff[CEIL_SEL_BIT];
  endsequence
  a_alarm_ceiling: assert property ( // RQ12
    s_alarm_ceil |=> fan_drive_1 == $past(ceil_ff[0]))
    else $error("fan 1 not at ceiling on alarm");
  a_alarm_full: assert property ( // RQ13
    s_alarm_full |=> fan_drive_3 == FULL_DUTY)
    else $error("fan 3 not at full duty on alarm");
  a_fan_follow_loop: assert property (
    !thermal_alarm_pin_s2_ff |=> fan_drive_2 == $past(fan_drive_2_loop))
    else $error("fan 2 not following the loop duty");

endmodule : tsdc_regs

// file: tb/tb.sv
// Self-checking bench for the step-interval and duty-ceiling register block
module tb
  import tsdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, mon_tick = 1'b0, thermal_alarm_pin = 1'b0;
  logic [2:0] step_done = 3'h0, dec_ok, inc_ok;
  logic [7:0] f1_in = 8'h11, f2_in = 8'h22, f3_in = 8'h33;
  logic [7:0] fan_drive_1, fan_drive_2, fan_drive_3;
  logic locked;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] q;
  // Rows: write flag, index, write data, expected read
  localparam logic [24:0] ROWS [13] = '{
    {1'b0, 8'h37, 8'h00, 8'h00}, {1'b0, 8'h38, 8'h00, 8'hff},
    {1'b0, 8'h39, 8'h00, 8'hff}, {1'b0, 8'h3a, 8'h00, 8'hff},
    {1'b0, 8'h36, 8'h00, 8'h00}, {1'b0, 8'h7d, 8'h00, 8'h00},
    {1'b1, 8'h37, 8'h78, 8'h78}, {1'b1, 8'h38, 8'h40, 8'h40},
    {1'b1, 8'h39, 8'h50, 8'h50}, {1'b1, 8'h3a, 8'h60, 8'h60},
    {1'b1, 8'h36, 8'h01, 8'h01}, {1'b1, 8'h7d, 8'h08, 8'h08},
    {1'b1, 8'h3b, 8'h5a, 8'h00}};
  localparam logic [2:0] CODES [3] = '{3'h0, 3'h7, 3'h5};

  tsdc_regs tsdc_regs_inst (.clk_sys(clk_sys), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_tick(mon_tick),
    .step_done(step_done), .thermal_alarm_pin(thermal_alarm_pin),
    .fan_drive_1_loop(f1_in), .fan_drive_2_loop(f2_in),
    .fan_drive_3_loop(f3_in), .dec_ok(dec_ok), .inc_ok(inc_ok),
    .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2),
    .fan_drive_3(fan_drive_3), .locked(locked));

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Compare one value against its expectation
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic Wishbone cycle; waits for ack under a bound
  task automatic wb_xfer(input logic we, input logic [7:0] idx,
                         input logic [7:0] d, input logic [3:0] sel,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= sel;
    // Ack and read data are taken as sampled at the rising edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  // Read a register and compare its content
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00, 4'h1, q);
    check("register", q, {24'h0, exp});
  endtask : rd_chk

  // Give n monitoring ticks, then let the outputs settle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      mon_tick <= 1'b1;
    end
    @(posedge clk_sys);
    mon_tick <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : ticks

  // Hold reset for 16 clock cycles
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : do_reset

  initial begin
    int nd;
    do_reset();
    // Reset values, then write and read back
    for (int i = 0; i < 13; i++) begin
      if (ROWS[i][24]) wb_xfer(1'b1, ROWS[i][23:16], ROWS[i][15:8], 4'h1, q);
      rd_chk(ROWS[i][23:16], ROWS[i][7:0]);
    end
    // Channel waits: remote A code 0, local code 7, remote B code 5
    for (int ch = 0; ch < 3; ch++) begin
      nd = BASE_DEC_CYCLES << CODES[ch];
      @(posedge clk_sys);
      step_done <= 3'h1 << ch;
      @(posedge clk_sys);
      step_done <= 3'h0;
      ticks(nd - 1);
      check("dec_ok early", dec_ok[ch], 1'b0);
      ticks(1);
      check("dec_ok due", dec_ok[ch], 1'b1);
      ticks(nd - 1);
      check("inc_ok early", inc_ok[ch], 1'b0);
      ticks(1);
      check("inc_ok due", inc_ok[ch], 1'b1);
    end
    // Alarm with ceiling select set, then clear, then alarm gone
    @(posedge clk_sys);
    thermal_alarm_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("fans ceiling", {fan_drive_1, fan_drive_2, fan_drive_3},
          32'h405060);
    rd_chk(IDX_STATUS, 8'h06);
    wb_xfer(1'b1, IDX_ALARM_CFG, 8'h00, 4'h1, q);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("fans full", {fan_drive_1, fan_drive_2, fan_drive_3},
          32'hffffff);
    @(posedge clk_sys);
    thermal_alarm_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("fans loop", {fan_drive_1, fan_drive_2, fan_drive_3},
          32'h112233);
    // Write without lane 0 select is ignored
    wb_xfer(1'b1, IDX_CEIL_2, 8'h99, 4'he, q);
    rd_chk(IDX_CEIL_2, 8'h50);
    // Lock, then attempt to change lockable registers
    wb_xfer(1'b1, IDX_CONFIG, 8'h02, 4'h1, q);
    wb_xfer(1'b1, IDX_STEP_CTRL, 8'h00, 4'h1, q);
    wb_xfer(1'b1, IDX_CEIL_1, 8'h11, 4'h1, q);
    wb_xfer(1'b1, IDX_CEIL_3, 8'h22, 4'h1, q);
    wb_xfer(1'b1, IDX_CONFIG, 8'h00, 4'h1, q);
    @(negedge clk_sys);
    check("locked", locked, 1'b1);
    rd_chk(IDX_STEP_CTRL, 8'h78);
    rd_chk(IDX_CEIL_1, 8'h40);
    rd_chk(IDX_CEIL_3, 8'h60);
    // Second reset clears the lock and restores defaults
    do_reset();
    @(negedge clk_sys);
    check("locked after reset", locked, 1'b0);
    rd_chk(IDX_STEP_CTRL, 8'h00);
    rd_chk(IDX_CEIL_1, 8'hff);
    finish_test();
  end

  // Guard against a hang
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
endmodule : tb
